// ===== src/fscr_defines.svh
`ifndef FSCR_DEFINES_SVH
`define FSCR_DEFINES_SVH
// instruction opcodes
`define FSCR_OP_WREN 8'h06
`define FSCR_OP_WRDI 8'h04
`define FSCR_OP_RDSR1 8'h05
`define FSCR_OP_RDSR2 8'h35
`define FSCR_OP_RDSR3 8'h15
`define FSCR_OP_WRSR1 8'h01
`define FSCR_OP_WRSR2 8'h31
`define FSCR_OP_WRSR3 8'h11
`define FSCR_OP_SUSP 8'h75
`define FSCR_OP_RESUME 8'h7a
`define FSCR_OP_EN4B 8'hb7
`define FSCR_OP_EX4B 8'he9
`define FSCR_OP_PFX1 8'haa
`define FSCR_OP_PFX2 8'h55
// bit positions inside status_one
`define FSCR_S1_BUSY 0
`define FSCR_S1_WEL 1
`define FSCR_S1_BP 2
`define FSCR_S1_TB 6
`define FSCR_S1_SRP 7
// bit positions inside status_two
`define FSCR_S2_SRL 0
`define FSCR_S2_QE 1
`define FSCR_S2_LB 3
`define FSCR_S2_CMP 6
`define FSCR_S2_SUS 7
// bit positions inside status_three
`define FSCR_S3_ADS 0
`define FSCR_S3_ADP 1
`define FSCR_S3_WPS 2
`define FSCR_S3_DRV 5
// factory values of the non-volatile fields
`define FSCR_RST_BP 4'h0
`define FSCR_RST_DRV 2'h3
// drive strength in percent
`define FSCR_DRV_P00 7'h64
`define FSCR_DRV_P01 7'h4b
`define FSCR_DRV_P10 7'h32
`define FSCR_DRV_P11 7'h19
// timing
`define FSCR_TW_NS 1600
`define FSCR_CLK_NS 100
`define FSCR_BLK_SHIFT 16
`endif

// ===== src/fscr_pkg.sv
package fscr_pkg;
   // writable configuration fields
   typedef struct packed {
      logic [3:0] bp;
      logic tb;
      logic status_protect_bit;
      logic status_lock_bit;
      logic qe;
      logic [2:0] lb;
      logic cmp;
      logic powerup_addr_mode;
      logic protect_scheme_select;
      logic [1:0] drv;
   } fscr_cfg_t;
   // one executed instruction
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] data;
   } fscr_cmd_t;
endpackage

// ===== src/fscr_regs.sv
// Operation
// - write enable sets write latch flag
// - latch cleared by disable, program, erase, writes
// - four block-protect bits, default zero
// - top_bottom_select zero top, one bottom
// - complement inverts chosen protected region
// - no protect bits: pin ignored, latch suffices
// - protect bit: low pin refuses writes
// - pin gates writes only outside quad
// - lock bit refuses writes until power cycle
// - prefix AAh 55h makes permanent lock; here reset clears it too
// - suspend sets flag, resume clears it
// - security locks only set, then read-only
// - quad enable swaps hold for data lines
// - status_three shows current address mode
// - powerup mode sampled at reset only
// - powerup mode picks three or four bytes; reset zeroes it before sampling, so always three
// - scheme select picks bits or block locks
// - all block locks set at reset
// - drive field decodes to percent strength
// - reserved bits read zero, writes ignored
// - protected target range refuses array operation
// - busy flag while write or operation
`timescale 1ns/1ps
`include "fscr_defines.svh"
`default_nettype none
module fscr_regs
   import fscr_pkg::*;
#(
   parameter int NUM_BLK = 512,
   parameter int BLK_W = 9,
   parameter int ADDR_W = 25,
   parameter int SR_WRITE_CYCLES = (`FSCR_TW_NS + `FSCR_CLK_NS - 1) / `FSCR_CLK_NS
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   input wire logic wp_n_i,
   input wire logic arr_req_i,
   input wire logic arr_sec_i,
   input wire logic [1:0] arr_sec_idx_i,
   input wire logic [ADDR_W-1:0] arr_lo_i,
   input wire logic [ADDR_W-1:0] arr_hi_i,
   input wire logic arr_done_i,
   output logic arr_accept_o,
   output logic arr_reject_o,
   input wire logic blk_unlock_i,
   input wire logic [BLK_W-1:0] blk_unlock_idx_i,
   output logic busy_o,
   output logic suspend_o,
   output logic quad_enable_o,
   output logic hold_enable_o,
   output logic addr4_mode_o,
   output logic [6:0] drive_pct_o
);
   // ---------------- link side, on sclk_i ----------------
   logic frame_rst; // frame logic clears while deselected
   logic [2:0] bit_cnt_reg; // bit within byte
   logic [6:0] shift_reg; // incoming bits
   logic [7:0] op_reg; // opcode of this frame
   logic have_op_reg; // opcode byte complete
   logic data_done_reg; // first data byte taken
   logic [7:0] tx_reg; // outgoing status byte
   logic miso_reg; // launched on falling edge
   logic oe_reg; // drive enable
   logic [7:0] in_byte; // byte ending at this edge
   logic [23:0] rb_s1_reg; // readback sync stage one
   logic [23:0] rb_s2_reg; // readback sync stage two
   logic [23:0] rb_img; // status image, clk side
   logic [23:0] rb_img_reg; // image from a flop, the crossing source
   fscr_cmd_t cmd_reg; // handed-over instruction
   logic tgl_reg; // flips once per instruction other than a read

   assign frame_rst = reset_i | cs_n_i;
   assign in_byte = {shift_reg, mosi_i};

   // reads are served locally on the link side
   function automatic logic is_rd(input logic [7:0] op);
      is_rd = (op == `FSCR_OP_RDSR1) || (op == `FSCR_OP_RDSR2) || (op == `FSCR_OP_RDSR3);
   endfunction

   // write-status opcodes carry one data byte
   function automatic logic is_wr(input logic [7:0] op);
      is_wr = (op == `FSCR_OP_WRSR1) || (op == `FSCR_OP_WRSR2) || (op == `FSCR_OP_WRSR3);
   endfunction

   // pick the status byte that an opcode reads
   function automatic logic [7:0] rd_sel(input logic [7:0] op, input logic [23:0] img);
      rd_sel = img[7:0];
      if (op == `FSCR_OP_RDSR2) begin
         rd_sel = img[15:8];
      end else if (op == `FSCR_OP_RDSR3) begin
         rd_sel = img[23:16];
      end
   endfunction

   // each status bit is an independent slow level, so a per-bit
   // two-flop crossing is enough; the opcode byte refreshes it
   always_ff @(posedge sclk_i or posedge reset_i) begin
      if (reset_i) begin
         rb_s1_reg <= 24'h000000;
         rb_s2_reg <= 24'h000000;
      end else begin
         rb_s1_reg <= rb_img_reg;
         rb_s2_reg <= rb_s1_reg;
      end
   end

   // frame shifter, cleared whenever chip select is high
   always_ff @(posedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_reg <= 3'h0;
         shift_reg <= 7'h00;
         op_reg <= 8'h00;
         have_op_reg <= 1'b0;
         data_done_reg <= 1'b0;
         tx_reg <= 8'h00;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         shift_reg <= in_byte[6:0];
         if (bit_cnt_reg == 3'h7) begin
            if (!have_op_reg) begin
               // opcode complete
               op_reg <= in_byte;
               have_op_reg <= 1'b1;
               tx_reg <= rd_sel(in_byte, rb_s2_reg);
            end else begin
               // repeated reads keep sending the same register
               data_done_reg <= 1'b1;
               tx_reg <= rd_sel(op_reg, rb_s2_reg);
            end
         end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   // output launched on the falling edge for a mode-0 host
   always_ff @(negedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         miso_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         miso_reg <= tx_reg[7];
         oe_reg <= have_op_reg & is_rd(op_reg);
      end
   end

   assign miso_o = miso_reg;
   assign miso_oe_o = oe_reg;

   // hand-over word; kept across frames so the toggle never glitches
   always_ff @(posedge sclk_i or posedge reset_i) begin
      if (reset_i) begin
         cmd_reg <= '0;
         tgl_reg <= 1'b0;
      end else if (!cs_n_i && bit_cnt_reg == 3'h7) begin
         if (!have_op_reg && !is_rd(in_byte) && !is_wr(in_byte)) begin
            cmd_reg <= '{op: in_byte, data: 8'h00};
            tgl_reg <= ~tgl_reg;
         end else if (have_op_reg && !data_done_reg && is_wr(op_reg)) begin
            cmd_reg <= '{op: op_reg, data: in_byte};
            tgl_reg <= ~tgl_reg;
         end
      end
   end

   // ---------------- register side, on clk_i ----------------
   logic tgl_s1_reg; // toggle sync stage one
   logic tgl_s2_reg; // toggle sync stage two
   logic tgl_s3_reg; // edge detect history
   logic wp_s1_reg; // protect pin sync one
   logic wp_s2_reg; // protect pin sync two
   logic cmd_new; // one instruction arrived
   fscr_cmd_t cmd; // its stable content
   fscr_cfg_t cfg_reg; // writable fields
   logic wel_reg; // write_latch_flag
   logic sus_reg; // suspend_flag
   logic ads_reg; // current_addr_mode
   logic otp_reg; // permanent status lock
   logic init_reg; // first cycle after reset
   logic [1:0] pfx_reg; // prefix progress
   logic [7:0] tw_cnt_reg; // status write timer
   logic arr_busy_reg; // array operation running
   logic acc_reg; // accept pulse
   logic rej_reg; // reject pulse
   logic [6:0] drv_pct_reg; // decoded strength
   logic [NUM_BLK-1:0] blk_lock_reg; // individual locks
   logic busy; // busy flag
   logic exec_ok; // instruction may run now
   logic sr_try; // write-status with latch set
   logic sr_ok; // status writes permitted
   logic sr_do; // write-status really executes
   logic prot_hit; // target touches protection

   // cmd_reg is stable for many clk cycles after the toggle settles
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
         wp_s1_reg <= 1'b0;
         wp_s2_reg <= 1'b0;
      end else begin
         tgl_s1_reg <= tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
         wp_s1_reg <= wp_n_i;
         wp_s2_reg <= wp_s1_reg;
      end
   end

   assign cmd_new = tgl_s2_reg ^ tgl_s3_reg;
   assign cmd = cmd_reg;
   assign busy = (tw_cnt_reg != 8'h00) | arr_busy_reg;
   // while busy only suspend and resume are obeyed
   assign exec_ok = cmd_new & (!busy | cmd.op == `FSCR_OP_SUSP | cmd.op == `FSCR_OP_RESUME);
   assign sr_try = exec_ok & is_wr(cmd.op) & wel_reg;
   // the pin counts only while it is not a quad data line
   assign sr_ok = !otp_reg & !cfg_reg.status_lock_bit
      & !(cfg_reg.status_protect_bit & !cfg_reg.qe & !wp_s2_reg);
   assign sr_do = sr_try & sr_ok;

   // configuration fields; reset stands for the power cycle
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg_reg <= '{bp: `FSCR_RST_BP, drv: `FSCR_RST_DRV, default: 1'b0};
      end else if (sr_do) begin
         unique case (cmd.op)
            `FSCR_OP_WRSR1: begin
               cfg_reg.bp <= cmd.data[`FSCR_S1_BP +: 4];
               cfg_reg.tb <= cmd.data[`FSCR_S1_TB];
               cfg_reg.status_protect_bit <= cmd.data[`FSCR_S1_SRP];
            end
            `FSCR_OP_WRSR2: begin
               cfg_reg.status_lock_bit <= cmd.data[`FSCR_S2_SRL];
               cfg_reg.qe <= cmd.data[`FSCR_S2_QE];
               cfg_reg.lb <= cfg_reg.lb | cmd.data[`FSCR_S2_LB +: 3];
               cfg_reg.cmp <= cmd.data[`FSCR_S2_CMP];
            end
            default: begin
               // status_three; only reachable after a write enable
               cfg_reg.powerup_addr_mode <= cmd.data[`FSCR_S3_ADP];
               cfg_reg.protect_scheme_select <= cmd.data[`FSCR_S3_WPS];
               cfg_reg.drv <= cmd.data[`FSCR_S3_DRV +: 2];
            end
         endcase
         // reserved and read-only bits of the data byte are dropped
      end
   end

   // prefix tracker and permanent lock
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pfx_reg <= 2'h0;
         otp_reg <= 1'b0;
      end else if (exec_ok) begin
         if (cmd.op == `FSCR_OP_PFX1) begin
            pfx_reg <= 2'h1;
         end else if (cmd.op == `FSCR_OP_PFX2 && pfx_reg == 2'h1) begin
            pfx_reg <= 2'h2;
         end else begin
            pfx_reg <= 2'h0;
         end
         if (sr_do && cmd.op == `FSCR_OP_WRSR2 && pfx_reg == 2'h2 && cmd.data[`FSCR_S2_SRL]) begin
            otp_reg <= 1'b1;
         end
      end
   end

   // write latch; a set in the same cycle as a clear wins
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wel_reg <= 1'b0;
      end else begin
         if (acc_next() || sr_do || (exec_ok && cmd.op == `FSCR_OP_WRDI)) begin
            wel_reg <= 1'b0;
         end
         if (exec_ok && cmd.op == `FSCR_OP_WREN) begin
            wel_reg <= 1'b1;
         end
      end
   end

   // suspend flag
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sus_reg <= 1'b0;
      end else if (exec_ok && cmd.op == `FSCR_OP_SUSP) begin
         sus_reg <= 1'b1;
      end else if (exec_ok && cmd.op == `FSCR_OP_RESUME) begin
         sus_reg <= 1'b0;
      end
   end

   // address mode is loaded from the power-up bit once, after release
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         init_reg <= 1'b1;
         ads_reg <= 1'b0;
      end else if (init_reg) begin
         init_reg <= 1'b0;
         ads_reg <= cfg_reg.powerup_addr_mode;
      end else if (exec_ok && cmd.op == `FSCR_OP_EN4B) begin
         ads_reg <= 1'b1;
      end else if (exec_ok && cmd.op == `FSCR_OP_EX4B) begin
         ads_reg <= 1'b0;
      end
   end

   // status write timer
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tw_cnt_reg <= 8'h00;
      end else if (sr_do) begin
         tw_cnt_reg <= 8'(SR_WRITE_CYCLES);
      end else if (tw_cnt_reg != 8'h00) begin
         tw_cnt_reg <= tw_cnt_reg - 8'h01;
      end
   end

   // protection decode
   logic [BLK_W:0] pcnt; // protected block count
   logic [BLK_W:0] rlo; // region first block
   logic [BLK_W:0] rhi; // region last block
   logic [BLK_W:0] tlo; // target first block
   logic [BLK_W:0] thi; // target last block
   logic bp_hit; // hit under the bit scheme
   logic [NUM_BLK-1:0] lk_vec; // locked blocks in target
   logic sec_locked; // security region locked

   assign tlo = {1'b0, arr_lo_i[`FSCR_BLK_SHIFT +: BLK_W]};
   assign thi = {1'b0, arr_hi_i[`FSCR_BLK_SHIFT +: BLK_W]};

   // fractions double per code; codes ten and up cover everything
   always_comb begin
      pcnt = '0;
      if (cfg_reg.bp >= 4'ha) begin
         pcnt = (BLK_W+1)'(NUM_BLK);
      end else if (cfg_reg.bp != 4'h0) begin
         pcnt = (BLK_W+1)'(1) << (cfg_reg.bp - 4'h1);
      end
      if (cfg_reg.tb) begin
         rlo = '0; // from the bottom
         rhi = pcnt - (BLK_W+1)'(1);
      end else begin
         rlo = (BLK_W+1)'(NUM_BLK) - pcnt; // from the top
         rhi = (BLK_W+1)'(NUM_BLK - 1);
      end
      if (cfg_reg.cmp) begin
         bp_hit = (pcnt == '0) || !(tlo >= rlo && thi <= rhi);
      end else begin
         bp_hit = (pcnt != '0) && tlo <= rhi && thi >= rlo;
      end
   end

   // one compare per block against the target range
   genvar g;
   generate
      for (g = 0; g < NUM_BLK; g++) begin : g_lk
         assign lk_vec[g] = blk_lock_reg[g] && (BLK_W+1)'(g) >= tlo && (BLK_W+1)'(g) <= thi;
      end
   endgenerate

   assign sec_locked = (arr_sec_idx_i == 2'h0) || cfg_reg.lb[arr_sec_idx_i - 2'h1];
   assign prot_hit = arr_sec_i ? sec_locked
      : (cfg_reg.protect_scheme_select ? (|lk_vec) : bp_hit);

   // accept needs latch, idle engine and no protected overlap
   function automatic logic acc_next();
      acc_next = arr_req_i & !busy & wel_reg & !prot_hit;
   endfunction

   // individual locks, all set at power-on and reset
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         blk_lock_reg <= '1;
      end else if (blk_unlock_i) begin
         blk_lock_reg[blk_unlock_idx_i] <= 1'b0;
      end
   end

   // array operation handshake
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         acc_reg <= 1'b0;
         rej_reg <= 1'b0;
         arr_busy_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next();
         rej_reg <= arr_req_i & !acc_next();
         if (acc_next()) begin
            arr_busy_reg <= 1'b1;
         end else if (arr_done_i) begin
            arr_busy_reg <= 1'b0;
         end
      end
   end

   // drive strength decode
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         drv_pct_reg <= `FSCR_DRV_P11;
      end else begin
         unique case (cfg_reg.drv)
            2'h0: drv_pct_reg <= `FSCR_DRV_P00;
            2'h1: drv_pct_reg <= `FSCR_DRV_P01;
            2'h2: drv_pct_reg <= `FSCR_DRV_P10;
            2'h3: drv_pct_reg <= `FSCR_DRV_P11;
         endcase
      end
   end

   // status image; reserved bits read zero
   always_comb begin
      rb_img = 24'h000000;
      rb_img[`FSCR_S1_BUSY] = busy;
      rb_img[`FSCR_S1_WEL] = wel_reg;
      rb_img[`FSCR_S1_BP +: 4] = cfg_reg.bp;
      rb_img[`FSCR_S1_TB] = cfg_reg.tb;
      rb_img[`FSCR_S1_SRP] = cfg_reg.status_protect_bit;
      rb_img[8 + `FSCR_S2_SRL] = cfg_reg.status_lock_bit | otp_reg;
      rb_img[8 + `FSCR_S2_QE] = cfg_reg.qe;
      rb_img[8 + `FSCR_S2_LB +: 3] = cfg_reg.lb;
      rb_img[8 + `FSCR_S2_CMP] = cfg_reg.cmp;
      rb_img[8 + `FSCR_S2_SUS] = sus_reg;
      rb_img[16 + `FSCR_S3_ADS] = ads_reg;
      rb_img[16 + `FSCR_S3_ADP] = cfg_reg.powerup_addr_mode;
      rb_img[16 + `FSCR_S3_WPS] = cfg_reg.protect_scheme_select;
      rb_img[16 + `FSCR_S3_DRV +: 2] = cfg_reg.drv;
   end

   // busy is a decode of several flops; launching the image from a flop
   // keeps its glitches away from the link-side synchroniser
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rb_img_reg <= 24'h000000;
      end else begin
         rb_img_reg <= rb_img;
      end
   end

   assign arr_accept_o = acc_reg;
   assign arr_reject_o = rej_reg;
   assign busy_o = busy;
   assign suspend_o = sus_reg;
   assign quad_enable_o = cfg_reg.qe;
   assign hold_enable_o = ~cfg_reg.qe;
   assign addr4_mode_o = ads_reg;
   assign drive_pct_o = drv_pct_reg;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_wren;
      exec_ok && cmd.op == `FSCR_OP_WREN;
   endsequence
   sequence s_busy_run;
      busy_o [*8];
   endsequence

   property p_wel_set;
      s_wren |=> wel_reg;
   endproperty
   a_wel_set: assert property (p_wel_set) else $error("latch not set");

   property p_wel_clr;
      sr_do && !(exec_ok && cmd.op == `FSCR_OP_WREN) |=> !wel_reg ##0 s_busy_run;
   endproperty
   a_wel_clr: assert property (p_wel_clr) else $error("write not timed");

   property p_lock_refuse;
      sr_try && (cfg_reg.status_lock_bit || otp_reg) |=> $stable(cfg_reg);
   endproperty
   a_lock_refuse: assert property (p_lock_refuse) else $error("locked write");

   property p_wp_refuse;
      sr_try && cfg_reg.status_protect_bit && !cfg_reg.qe && !wp_s2_reg |=> $stable(cfg_reg);
   endproperty
   a_wp_refuse: assert property (p_wp_refuse) else $error("pin ignored");

   property p_otp_hold;
      otp_reg |=> otp_reg && !sr_ok;
   endproperty
   a_otp_hold: assert property (p_otp_hold) else $error("lock lost");

   property p_sus_set;
      exec_ok && cmd.op == `FSCR_OP_SUSP |=> suspend_o;
   endproperty
   a_sus_set: assert property (p_sus_set) else $error("no suspend");

   property p_prot_block;
      arr_req_i && prot_hit |=> !arr_accept_o && arr_reject_o;
   endproperty
   a_prot_block: assert property (p_prot_block) else $error("protected op");

   property p_ads_init;
      init_reg |=> addr4_mode_o == $past(cfg_reg.powerup_addr_mode);
   endproperty
   a_ads_init: assert property (p_ads_init) else $error("bad mode");

   property p_drive;
      cfg_reg.drv == 2'h1 ##1 cfg_reg.drv == 2'h1 |-> drive_pct_o == `FSCR_DRV_P01;
   endproperty
   a_drive: assert property (p_drive) else $error("bad drive");
endmodule // fscr_regs
`default_nettype wire

// ===== verification/fscr_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module fscr_spi_host (
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   // link clock rests low between frames, mode 0
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // one frame, msb first: opcode and, if two, a data byte; rd holds the answer
   task automatic xfer(input logic [7:0] op, input logic [7:0] d, input bit two,
         output logic [7:0] rd);
      logic [15:0] sh;
      sh = {op, d};
      rd = 8'h00;
      #13 cs_n_o = 1'b0;
      for (int i = 0; i < (two ? 16 : 8); i++) begin
         mosi_o = sh[15-i];
         #40 sclk_o = 1'b1;
         if (i >= 8)
            rd = {rd[6:0], miso_i};
         #40 sclk_o = 1'b0;
      end
      #40 cs_n_o = 1'b1;
      // released line shows the inverse, so a stale bit cannot pass
      mosi_o = ~mosi_o;
      #40;
   endtask
endmodule // fscr_spi_host
`default_nettype wire

// ===== verification/tb_fscr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fscr_regs;
   logic clk_i, reset_i, sclk, cs_n, mosi, miso, wp_n_i, req, done, unl, sec;
   logic [1:0] sidx;
   logic [24:0] lo;
   logic acc, rej, busy_o, sus_o, quad_o, hold_o, a4_o;
   logic [6:0] drv_o;
   logic [7:0] rd;
   logic [6:0] pct [4] = '{7'h64, 7'h4b, 7'h32, 7'h19};
   int fails = 0;
   int checks_done = 0;
   // clocks and time-zero values
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      {reset_i, wp_n_i, req, done, unl, lo} = {5'b11000, 25'h0};
      {sec, sidx} = 3'h0;
   end
   fscr_spi_host fscr_spi_host_inst (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
      .miso_i(miso));
   fscr_regs #(.SR_WRITE_CYCLES(8)) fscr_regs_inst (.clk_i(clk_i), .reset_i(reset_i),
      .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(),
      .wp_n_i(wp_n_i), .arr_req_i(req), .arr_sec_i(sec), .arr_sec_idx_i(sidx),
      .arr_lo_i(lo), .arr_hi_i(lo | 25'h000ffff), .arr_done_i(done),
      .arr_accept_o(acc), .arr_reject_o(rej), .blk_unlock_i(unl),
      .blk_unlock_idx_i(9'h000), .busy_o(busy_o), .suspend_o(sus_o),
      .quad_enable_o(quad_o), .hold_enable_o(hold_o), .addr4_mode_o(a4_o),
      .drive_pct_o(drv_o));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (fails == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // inputs move 1 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic rst();
      reset_i = 1'b1;
      cyc(2);
      reset_i = 1'b0;
      cyc(4);
   endtask
   task automatic op1(input logic [7:0] op);
      fscr_spi_host_inst.xfer(op, 8'h00, 1'b0, rd);
      cyc(6);
   endtask
   task automatic rdsr(input logic [7:0] op, input logic [7:0] exp);
      fscr_spi_host_inst.xfer(op, 8'h00, 1'b1, rd);
      check(rd, exp);
   endtask
   // bounded wait for the busy flag to drop
   task automatic idle();
      int k;
      k = 0;
      while (busy_o !== 1'b0 && k < 100) begin
         cyc(1);
         k++;
      end
      if (k == 100) begin
         fails++;
         report_and_stop();
      end
   endtask
   // write enable, then a status write; reserved bits always sent as 0
   task automatic wsr(input logic [7:0] op, input logic [7:0] d);
      op1(8'h06);
      fscr_spi_host_inst.xfer(op, d, 1'b1, rd);
      cyc(6);
      idle();
   endtask
   // array request with latch set; exp is {accept, reject}
   task automatic arr(input logic [24:0] a, input logic [1:0] exp);
      op1(8'h06);
      lo = a;
      req = 1'b1;
      cyc(1);
      req = 1'b0;
      check({6'h0, acc, rej}, {6'h0, exp});
      if (exp == 2'b10) begin
         cyc(2);
         check({7'h0, busy_o}, 8'h01);
         done = 1'b1;
         cyc(1);
         done = 1'b0;
         cyc(2);
         check({7'h0, busy_o}, 8'h00);
      end
   endtask
   task automatic t_reset();
      check({3'h0, busy_o, sus_o, quad_o, hold_o, a4_o}, 8'h02);
      check({1'b0, drv_o}, 8'h19);
      rdsr(8'h05, 8'h00);
      rdsr(8'h35, 8'h00);
      rdsr(8'h15, 8'h60);
      op1(8'h06);
      rdsr(8'h05, 8'h02);
      op1(8'h04);
      rdsr(8'h05, 8'h00);
   endtask
   task automatic t_drive();
      for (int d = 0; d < 4; d++) begin
         wsr(8'h11, {1'b0, d[1:0], 5'h00});
         check({1'b0, drv_o}, {1'b0, pct[d]});
         rdsr(8'h15, {1'b0, d[1:0], 5'h00});
         rdsr(8'h05, 8'h00);
      end
      op1(8'h75);
      rdsr(8'h35, 8'h80);
      op1(8'h7a);
      check({7'h0, sus_o}, 8'h00);
   endtask
   task automatic t_wp();
      wsr(8'h01, 8'h80);
      wp_n_i = 1'b0;
      wsr(8'h01, 8'h84);
      rdsr(8'h05, 8'h82);
      wp_n_i = 1'b1;
      wsr(8'h01, 8'h84);
      rdsr(8'h05, 8'h84);
      wsr(8'h31, 8'h02);
      check({6'h0, quad_o, hold_o}, 8'h02);
      wp_n_i = 1'b0;
      wsr(8'h01, 8'h80);
      rdsr(8'h05, 8'h80);
      wsr(8'h31, 8'h00);
      wp_n_i = 1'b1;
      wsr(8'h01, 8'h00);
      // no protect bit: a low pin must not block the write
      wp_n_i = 1'b0;
      wsr(8'h01, 8'h04);
      rdsr(8'h05, 8'h04);
      wsr(8'h01, 8'h00);
      wp_n_i = 1'b1;
   endtask
   task automatic t_array();
      wsr(8'h01, 8'h04);
      arr(25'h1ff0000, 2'b01);
      arr(25'h0000000, 2'b10);
      rdsr(8'h05, 8'h04);
      wsr(8'h01, 8'h44);
      arr(25'h0000000, 2'b01);
      wsr(8'h31, 8'h40);
      arr(25'h1ff0000, 2'b01);
      arr(25'h0000000, 2'b10);
      wsr(8'h11, 8'h64);
      arr(25'h1ff0000, 2'b01);
      unl = 1'b1;
      cyc(1);
      unl = 1'b0;
      arr(25'h0000000, 2'b10);
      wsr(8'h11, 8'h60);
      wsr(8'h31, 8'h00);
      wsr(8'h01, 8'h00);
   endtask
   task automatic t_lock();
      wsr(8'h31, 8'h08);
      wsr(8'h31, 8'h00);
      rdsr(8'h35, 8'h08);
      // security region one is locked, region two still open
      sec = 1'b1;
      sidx = 2'h1;
      arr(25'h0000000, 2'b01);
      sidx = 2'h2;
      arr(25'h0000000, 2'b10);
      sec = 1'b0;
      wsr(8'h31, 8'h09);
      wsr(8'h01, 8'h04);
      rdsr(8'h05, 8'h02);
      rst();
      wsr(8'h01, 8'h04);
      rdsr(8'h05, 8'h04);
      // latch, then the two prefix bytes, then the locking write
      op1(8'h06);
      op1(8'haa);
      op1(8'h55);
      fscr_spi_host_inst.xfer(8'h31, 8'h01, 1'b1, rd);
      cyc(6);
      idle();
      wsr(8'h01, 8'h00);
      rdsr(8'h35, 8'h01);
      rdsr(8'h05, 8'h06);
      rst();
   endtask
   task automatic t_addr();
      op1(8'hb7);
      check({7'h0, a4_o}, 8'h01);
      op1(8'he9);
      wsr(8'h11, 8'h62);
      check({7'h0, a4_o}, 8'h00);
      rdsr(8'h15, 8'h62);
      // reset stands for a power cycle: the power-up bit returns to factory zero
      rst();
      check({7'h0, a4_o}, 8'h00);
      rdsr(8'h15, 8'h60);
   endtask
   // main sequence
   initial begin
      cyc(2);
      reset_i = 1'b0;
      cyc(4);
      t_reset();
      t_drive();
      t_wp();
      t_array();
      t_lock();
      t_addr();
      report_and_stop();
   end
endmodule // tb_fscr_regs
`default_nettype wire
